// [rtl/kpi_consts.svh]
// register offsets, field positions and reset values of the keypad interrupt unit
`ifndef KPI_CONSTS_SVH
`define KPI_CONSTS_SVH
`define KPI_OFF_STATUS_CONTROL 12'h000
`define KPI_OFF_PIN_ENABLE 12'h004
`define KPI_OFF_POLARITY_SELECT 12'h008
`define KPI_BIT_DETECT_FLAG 3
`define KPI_BIT_FLAG_ACK 2
`define KPI_BIT_IRQ_ENABLE 1
`define KPI_BIT_SENSE_MODE 0
`define KPI_RST_STATUS_CONTROL 8'h00
`define KPI_RST_PIN_ENABLE 8'h00
`define KPI_RST_POLARITY_SELECT 8'h00
`define KPI_ADDR_BITS 12
`define KPI_PINS 8
`endif

// [rtl/kpi_keypad_irq_unit.sv]
// keypad interrupt unit with ahb-lite register slave
// What this block does
// - each keypad pin has its own enable bit and only enabled pins can be detected.
// - all pins sense edges only or edges and levels by one mode bit, each with falling/low or rising/high polarity.
// - all enabled pins feed one interrupt request gated by one enable bit.
// - detection continues in wait mode and wakes the device when the enable bit is 1.
// - in stop mode no pin is seen here without a clock; stop_wake, the registered enable bit, permits the outside wake path.
// - in background debug mode the unit keeps running exactly as in run mode.
// - status/control holds zeros in 7:4, the flag at 3, a write-only ack at 2, enable at 1, mode at 0.
// - an 8-bit read/write pin enable register enables pin n with bit n.
// - an 8-bit read/write polarity register selects polarity of pin n with bit n.
// - an edge is deasserted then asserted on consecutive cycles, re-armed only when all enabled pins are deasserted.
// - polarity 0 means falling edge and low level, 1 means rising edge and high level.
// - writes to the flag do nothing and writing 1 to the ack bit clears it; ack reads as 0.
// - in edge-and-level mode an ack leaves the flag set while any enabled pin is asserted.
//
// Local design decisions: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "kpi_consts.svh"
module kpi_keypad_irq_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [7:0] keypad_input_pin,
    output logic irq_request,
    output logic stop_wake
);
    kpi_pkg::kpi_byte_t pin_enable;
    kpi_pkg::kpi_byte_t polarity;
    logic irq_enable_bit;
    logic sense_mode_select;
    logic detect_flag;
    logic armed;
    logic wr_pend;
    logic [`KPI_ADDR_BITS-1:0] wr_addr;
    kpi_pkg::kpi_byte_t next_pin_enable;
    kpi_pkg::kpi_byte_t next_polarity;
    logic next_irq_enable_bit;
    logic next_sense_mode_select;
    logic next_detect_flag;
    logic next_armed;
    logic next_wr_pend;
    logic [`KPI_ADDR_BITS-1:0] next_wr_addr;
    logic [31:0] next_hrdata;
    logic next_irq_request;
    logic next_stop_wake;
    logic next_hreadyout;
    logic next_hresp;
    logic [7:0] pin_sync;
    logic [7:0] pin_asserted;
    logic [7:0] pin_rose;
    logic any_asserted;
    logic edge_event;
    logic level_event;
    logic ack_write;
    logic addr_phase;
    kpi_pkg::kpi_byte_t wbyte;

    // synchronise and detect each pin
    genvar gi;
    generate
        for (gi = 0; gi < `KPI_PINS; gi = gi + 1)
        begin : g_pin
            kpi_sync_bit u_sync (
                .clk(clk),
                .rst(rst),
                .d(keypad_input_pin[gi]),
                .q(pin_sync[gi])
            );
            kpi_pin_detect u_det (
                .clk(clk),
                .rst(rst),
                .pin_sync(pin_sync[gi]),
                .polarity(polarity[gi]),
                .enable(pin_enable[gi]),
                .asserted(pin_asserted[gi]),
                .rose(pin_rose[gi])
            );
        end
    endgenerate

    // bus decode and register update
    always_comb
    begin
        addr_phase = hsel & hready & htrans[1];
        wbyte = hwdata[7:0];
        any_asserted = |pin_asserted;
        edge_event = armed & (|pin_rose);
        level_event = sense_mode_select & any_asserted;
        ack_write = wr_pend && wr_addr == `KPI_OFF_STATUS_CONTROL && wbyte[`KPI_BIT_FLAG_ACK];
        next_wr_pend = addr_phase & hwrite;
        next_wr_addr = addr_phase ? haddr[`KPI_ADDR_BITS-1:0] : wr_addr;
        next_pin_enable = pin_enable;
        next_polarity = polarity;
        next_irq_enable_bit = irq_enable_bit;
        next_sense_mode_select = sense_mode_select;
        if (wr_pend)
        begin
            case (wr_addr)
                `KPI_OFF_STATUS_CONTROL:
                begin
                    next_irq_enable_bit = wbyte[`KPI_BIT_IRQ_ENABLE];
                    next_sense_mode_select = wbyte[`KPI_BIT_SENSE_MODE];
                end
                `KPI_OFF_PIN_ENABLE: next_pin_enable = wbyte;
                `KPI_OFF_POLARITY_SELECT: next_polarity = wbyte;
                default: ;
            endcase
        end
        // flag: set wins over ack, writes to bit 3 ignored
        next_detect_flag = detect_flag;
        if (ack_write)
            next_detect_flag = 1'b0;
        if (edge_event | level_event)
            next_detect_flag = 1'b1;
        // re-arm only once all enabled pins are deasserted
        next_armed = armed;
        if (edge_event)
            next_armed = 1'b0;
        if (!any_asserted)
            next_armed = 1'b1;
        // reads answer in the data phase; no wait states
        // the next values are shown, so a read right behind a write sees that write
        next_hrdata = 32'h0000_0000;
        if (addr_phase & ~hwrite)
        begin
            case (haddr[`KPI_ADDR_BITS-1:0])
                `KPI_OFF_STATUS_CONTROL: next_hrdata = {24'h00_0000, 4'h0,
                    next_detect_flag, 1'b0, next_irq_enable_bit, next_sense_mode_select};
                `KPI_OFF_PIN_ENABLE: next_hrdata = {24'h00_0000, next_pin_enable};
                `KPI_OFF_POLARITY_SELECT: next_hrdata = {24'h00_0000, next_polarity};
                default: next_hrdata = 32'h0000_0000;
            endcase
        end
        next_irq_request = next_detect_flag & next_irq_enable_bit;
        // wake permission for the stop-mode wake path outside this clock domain
        next_stop_wake = next_irq_enable_bit;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pin_enable <= `KPI_RST_PIN_ENABLE;
            polarity <= `KPI_RST_POLARITY_SELECT;
            irq_enable_bit <= 1'b0;
            sense_mode_select <= 1'b0;
            detect_flag <= 1'b0;
            armed <= 1'b0;
            wr_pend <= 1'b0;
            wr_addr <= '0;
            hrdata <= 32'h0000_0000;
            irq_request <= 1'b0;
            stop_wake <= 1'b0;
        end
        else
        begin
            pin_enable <= next_pin_enable;
            polarity <= next_polarity;
            irq_enable_bit <= next_irq_enable_bit;
            sense_mode_select <= next_sense_mode_select;
            detect_flag <= next_detect_flag;
            armed <= next_armed;
            wr_pend <= next_wr_pend;
            wr_addr <= next_wr_addr;
            hrdata <= next_hrdata;
            irq_request <= next_irq_request;
            stop_wake <= next_stop_wake;
        end
    end

    // bus handshake: the slave never stalls and never signals an error
    always_comb
    begin
        next_hreadyout = 1'b1;
        next_hresp = 1'b0;
    end

    // handshake outputs also leave from flops, ready out of reset
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= next_hreadyout;
            hresp <= next_hresp;
        end
    end

    // an armed unit sees a fresh edge on some enabled pin
    sequence s_rise;
        armed && |pin_rose;
    endsequence

    // the flag goes from clear to set over one edge
    sequence s_flag_rise;
        !detect_flag ##1 detect_flag;
    endsequence

    // a read of the status/control register is taken
    sequence s_status_read;
        addr_phase && !hwrite && haddr[`KPI_ADDR_BITS-1:0] == `KPI_OFF_STATUS_CONTROL;
    endsequence

    // an acknowledge arrives while a level-mode pin is still held
    sequence s_ack_while_held;
        ack_write && sense_mode_select && any_asserted;
    endsequence

    // a status write without acknowledge and with no detection pending
    sequence s_flag_only_write;
        wr_pend && wr_addr == `KPI_OFF_STATUS_CONTROL && !wbyte[`KPI_BIT_FLAG_ACK]
            && !edge_event && !level_event;
    endsequence

    // detection: edges, levels, acknowledge and re-arming
    a_edge_sets_flag: assert property (
        @(posedge clk) disable iff (rst) s_rise |=> detect_flag)
        else $error("edge did not set flag");
    a_level_holds: assert property (
        @(posedge clk) disable iff (rst) sense_mode_select && any_asserted |=> detect_flag)
        else $error("level lost");
    a_ack_in_level: assert property (
        @(posedge clk) disable iff (rst) s_ack_while_held |=> detect_flag)
        else $error("ack cleared a held level");
    a_flag_cause: assert property (
        @(posedge clk) disable iff (rst) s_flag_rise |-> $past(edge_event || level_event))
        else $error("flag set without a cause");
    a_edge_mode_quiet: assert property (
        @(posedge clk) disable iff (rst)
        !sense_mode_select && !detect_flag && !edge_event |=> !detect_flag)
        else $error("level set flag in edge mode");
    a_rearm_idle: assert property (
        @(posedge clk) disable iff (rst) edge_event && any_asserted |=> !armed)
        else $error("rearm early");
    a_rearm_free: assert property (
        @(posedge clk) disable iff (rst) !any_asserted |=> armed)
        else $error("not re-armed when idle");
    a_ack_clears: assert property (
        @(posedge clk) disable iff (rst)
        ack_write && !edge_event && !level_event |=> !detect_flag)
        else $error("ack failed");
    a_flag_write_ignored: assert property (
        @(posedge clk) disable iff (rst) s_flag_only_write |=> detect_flag == $past(detect_flag))
        else $error("write changed the flag");

    // pin qualification, polarity and synchronising
    a_disabled_quiet: assert property (
        @(posedge clk) disable iff (rst) pin_enable == 8'h00 |-> pin_asserted == 8'h00)
        else $error("disabled pin seen");
    a_only_enabled: assert property (
        @(posedge clk) disable iff (rst) (pin_asserted & ~pin_enable) == 8'h00)
        else $error("disabled pin asserted");
    a_low_asserts: assert property (
        @(posedge clk) disable iff (rst)
        (pin_asserted & ~polarity) == (pin_enable & ~polarity & ~pin_sync))
        else $error("low polarity misread");
    a_high_asserts: assert property (
        @(posedge clk) disable iff (rst)
        (pin_asserted & polarity) == (pin_enable & polarity & pin_sync))
        else $error("high polarity misread");
    a_sync_two_stage: assert property (
        @(posedge clk) disable iff (rst)
        !$past(rst) && !$past(rst, 2) |-> pin_sync == $past(keypad_input_pin, 2))
        else $error("pin not delayed by two flops");

    // register writes and reads
    a_pe_write: assert property (
        @(posedge clk) disable iff (rst) wr_pend && wr_addr == `KPI_OFF_PIN_ENABLE
        |=> pin_enable == $past(hwdata[7:0]))
        else $error("pin enable write lost");
    a_pol_write: assert property (
        @(posedge clk) disable iff (rst) wr_pend && wr_addr == `KPI_OFF_POLARITY_SELECT
        |=> polarity == $past(hwdata[7:0]))
        else $error("polarity write lost");
    a_status_read: assert property (
        @(posedge clk) disable iff (rst)
        s_status_read |=> hrdata[7:4] == 4'h0 && !hrdata[`KPI_BIT_FLAG_ACK])
        else $error("status read shows reserved or ack bits");
    a_upper_zero: assert property (
        @(posedge clk) disable iff (rst) hrdata[31:8] == 24'h00_0000)
        else $error("upper read bits not zero");

    // request outputs
    a_irq_follows: assert property (
        @(posedge clk) disable iff (rst) irq_request == $past(next_irq_request))
        else $error("irq mismatch");
    a_irq_needs_en: assert property (
        @(posedge clk) disable iff (rst) irq_request |-> $past(irq_enable_bit) || $past(wr_pend))
        else $error("irq without enable");
    a_irq_level: assert property (
        @(posedge clk) disable iff (rst) irq_request == (detect_flag && irq_enable_bit))
        else $error("request differs from flag and enable");
    a_wake_permit: assert property (
        @(posedge clk) disable iff (rst) stop_wake == irq_enable_bit)
        else $error("wake permission differs from enable");
endmodule // kpi_keypad_irq_unit

// [rtl/kpi_pin_detect.sv]
// per-pin asserted-level and edge detect for the keypad interrupt unit
`timescale 1ns/1ps
module kpi_pin_detect (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_sync,
    input wire logic polarity,
    input wire logic enable,
    output logic asserted,
    output logic rose
);
    logic prev_asserted;
    logic next_prev_asserted;

    // polarity 0 means low asserts, 1 means high asserts
    always_comb
    begin
        asserted = enable & (pin_sync ~^ polarity);
        next_prev_asserted = asserted;
        rose = asserted & ~prev_asserted;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            prev_asserted <= 1'b1;
        else
            prev_asserted <= next_prev_asserted;
    end
endmodule // kpi_pin_detect

// [rtl/kpi_pkg.sv]
// types of the keypad interrupt unit
package kpi_pkg;
    typedef enum logic [1:0] {KPI_IDLE, KPI_ADDR, KPI_DATA} kpi_bus_state_e;
    typedef logic [7:0] kpi_byte_t;
endpackage

// [rtl/kpi_sync_bit.sv]
// two-stage synchroniser for one keypad pin
`timescale 1ns/1ps
module kpi_sync_bit (
    input wire logic clk,
    input wire logic rst,
    input wire logic d,
    output logic q
);
    logic meta;
    logic next_meta;
    logic next_q;

    // shift the pin through two flops
    always_comb
    begin
        next_meta = d;
        next_q = meta;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta <= 1'b0;
            q <= 1'b0;
        end
        else
        begin
            meta <= next_meta;
            q <= next_q;
        end
    end
endmodule // kpi_sync_bit

// [verif/kpi_keypad_model.sv]
// keypad switch model driving the raw keypad pins
`timescale 1ns/1ps
module kpi_keypad_model (
    input wire logic clk,
    input wire logic [7:0] polarity,
    input wire logic [7:0] pressed,
    output logic [7:0] pins = 8'hff
);
    // a held key sits at its asserted level, a free key at the deasserted one
    always @(posedge clk)
    begin
        pins <= ~(pressed ^ polarity);
    end
endmodule // kpi_keypad_model

// [verif/test_kpi_keypad_irq_unit.sv]
// self-checking bench of the keypad interrupt unit
`timescale 1ns/1ps
`include "kpi_consts.svh"
module test_kpi_keypad_irq_unit;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout;
    logic hresp;
    logic [7:0] pins;
    logic [7:0] mpol = 8'h00;
    logic [7:0] press = 8'h00;
    logic irq_request;
    logic stop_wake;
    logic [31:0] rd;
    logic [7:0] en, pol, ctl, key, fl;
    int n_mismatch = 0;
    int n_tests = 0;
    // rows: enable, polarity, control (ie bit 1, mode bit 0), keys held, expected flag
    logic [39:0] rows [6] = '{40'h01_00_02_01_01, 40'h80_80_02_80_01, 40'h01_00_02_02_00,
        40'hff_aa_02_04_01, 40'h20_ff_00_20_01, 40'h0f_0f_03_08_01};

    kpi_keypad_irq_unit i_kpi_keypad_irq_unit (.clk(clk), .rst(rst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .keypad_input_pin(pins), .irq_request(irq_request), .stop_wake(stop_wake));
    kpi_keypad_model i_kpi_keypad_model (.clk(clk), .polarity(mpol), .pressed(press),
        .pins(pins));

    // 50 MHz clock
    always #10 clk = ~clk;

    // count a comparison and report a difference
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one single ahb-lite transfer, waiting on hready in both phases
    task automatic bus(input logic wr, input logic [11:0] addr, input logic [7:0] data);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {20'h0, addr};
        hwrite <= wr;
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h0, data};
        @(posedge clk);
        while (hreadyout !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    // read a register and compare it with an expected byte
    task automatic expect_reg(input logic [11:0] addr, input logic [7:0] exp);
        bus(1'b0, addr, 8'h00);
        check(rd, {24'h0, exp});
        check({hreadyout, hresp}, 2'b10);
    endtask

    // print the verdict and stop
    task automatic complete_run;
        if (n_mismatch == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // hang guard
    initial
    begin
        #200000;
        n_mismatch++;
        complete_run;
    end

    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        foreach (rows[i])
        begin
            {en, pol, ctl, key, fl} = rows[i];
            bus(1'b1, `KPI_OFF_PIN_ENABLE, 8'h00);
            mpol <= pol;
            bus(1'b1, `KPI_OFF_POLARITY_SELECT, pol);
            bus(1'b1, `KPI_OFF_PIN_ENABLE, en);
            bus(1'b1, `KPI_OFF_STATUS_CONTROL, ctl | 8'h04);
            press <= key;
            repeat (6) @(posedge clk);
            expect_reg(`KPI_OFF_STATUS_CONTROL, {4'h0, fl[0], 1'b0, ctl[1:0]});
            check(irq_request, fl[0] & ctl[1]);
            check(stop_wake, ctl[1]);
            expect_reg(`KPI_OFF_PIN_ENABLE, en);
            expect_reg(`KPI_OFF_POLARITY_SELECT, pol);
            press <= 8'h00;
            repeat (4) @(posedge clk);
            bus(1'b1, `KPI_OFF_STATUS_CONTROL, ctl | 8'h04);
            expect_reg(`KPI_OFF_STATUS_CONTROL, {6'h0, ctl[1:0]});
        end
        // level mode: the flag survives an ack while a key is held
        press <= 8'h02;
        repeat (6) @(posedge clk);
        bus(1'b1, `KPI_OFF_STATUS_CONTROL, 8'h07);
        expect_reg(`KPI_OFF_STATUS_CONTROL, 8'h0b);
        press <= 8'h00;
        repeat (4) @(posedge clk);
        bus(1'b1, `KPI_OFF_STATUS_CONTROL, 8'h07);
        expect_reg(`KPI_OFF_STATUS_CONTROL, 8'h03);
        // edge mode: no new edge counts until every enabled key is released
        bus(1'b1, `KPI_OFF_STATUS_CONTROL, 8'h06);
        press <= 8'h01;
        repeat (6) @(posedge clk);
        bus(1'b1, `KPI_OFF_STATUS_CONTROL, 8'h06);
        press <= 8'h03;
        repeat (6) @(posedge clk);
        expect_reg(`KPI_OFF_STATUS_CONTROL, 8'h02);
        press <= 8'h00;
        repeat (4) @(posedge clk);
        press <= 8'h02;
        repeat (6) @(posedge clk);
        expect_reg(`KPI_OFF_STATUS_CONTROL, 8'h0a);
        check(irq_request, 1'b1);
        press <= 8'h00;
        // flag and upper bits ignore writes; ack alone clears
        bus(1'b1, `KPI_OFF_STATUS_CONTROL, 8'hf8);
        expect_reg(`KPI_OFF_STATUS_CONTROL, 8'h08);
        check(irq_request, 1'b0);
        bus(1'b1, `KPI_OFF_STATUS_CONTROL, 8'h04);
        expect_reg(`KPI_OFF_STATUS_CONTROL, 8'h00);
        // unmapped word reads zero
        bus(1'b1, 12'h00c, 8'hff);
        expect_reg(12'h00c, 8'h00);
        // reset in mid-run returns every register to zero
        bus(1'b1, `KPI_OFF_STATUS_CONTROL, 8'h03);
        rst <= 1'b1;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        expect_reg(`KPI_OFF_STATUS_CONTROL, `KPI_RST_STATUS_CONTROL);
        expect_reg(`KPI_OFF_PIN_ENABLE, `KPI_RST_PIN_ENABLE);
        expect_reg(`KPI_OFF_POLARITY_SELECT, `KPI_RST_POLARITY_SELECT);
        check(stop_wake, 1'b0);
        complete_run;
    end
endmodule // test_kpi_keypad_irq_unit
